/* File: rtl/param_timing_axil.v */
// AXI4-Lite slave exposing the parameter-page timing-capability table
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "param_timing_defines.vh"

// Function
// - Async mode mask 3Fh,00h at 144-145
// - DDR mask per variant at 148-149
// - Sync feature byte 152 reads 00h
// - Program time C4h,09h at 153-154
// - Erase time E0h,2Eh at 155-156
// - Page read time 4Bh,00h at 157-158
// - Multi-plane read time 4Bh,00h at 159-160
// - Column change setup C8h,00h at 161-162
module param_timing_axil #(
    parameter ADDR_W = 12 // Byte address width
) (
    input wire aclk, // Clock, 125 MHz
    input wire aresetn, // Synchronous reset, active low
    input wire [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire [2:0] s_axi_awprot, // Write protection, ignored
    input wire s_axi_awvalid, // Write address valid
    output reg s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write byte strobes
    input wire s_axi_wvalid, // Write data valid
    output reg s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire [2:0] s_axi_arprot, // Read protection, ignored
    input wire s_axi_arvalid, // Read address valid
    output reg s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready // Read data ready
);

    // ------------------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------------------

    // Word index of a byte address
    function [9:0] word_index;
        input [ADDR_W-1:0] addr;
        begin
            word_index = addr[11:2];
        end
    endfunction

    // Only word-aligned accesses are honoured
    function aligned;
        input [ADDR_W-1:0] addr;
        begin
            aligned = (addr[1:0] == 2'h0);
        end
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg [1:0] variant; // Selected synchronous speed-grade variant
    reg aw_held; // Write address taken, waiting for data
    reg w_held; // Write data taken, waiting for address
    reg [ADDR_W-1:0] aw_addr; // Captured write address
    reg [31:0] w_data; // Captured write data
    reg [3:0] w_strb; // Captured write strobes

    wire [7:0] table_byte;
    wire table_hit;
    wire aw_take;
    wire w_take;
    wire ar_take;
    wire wr_commit;
    wire [9:0] wr_index;
    wire [9:0] rd_index;
    wire rd_aligned;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    // Both halves present and no response pending
    assign wr_commit = aw_held && w_held && !s_axi_bvalid;
    assign wr_index = word_index(aw_addr);
    assign rd_index = word_index(s_axi_araddr);
    assign rd_aligned = aligned(s_axi_araddr);

    // ------------------------------------------------------------------------
    // Constant table
    // ------------------------------------------------------------------------
    // Lookup is combinational off the live read address so data lands
    // in the same edge that takes the address
    timing_table_rom u_table (
        .byte_index(rd_index),
        .variant(variant),
        .byte_data(table_byte),
        .hit(table_hit)
    );

    // ------------------------------------------------------------------------
    // Write address channel
    // ------------------------------------------------------------------------
    // Ready drops once an address is held and returns after the response
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b0;
            aw_addr <= {ADDR_W{1'b0}};
        end else if (aw_take) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            aw_held <= 1'b0;
        end else if (!aw_held && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Write data channel
    // ------------------------------------------------------------------------
    // Independent of the address channel so either may arrive first
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (w_take) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
            w_held <= 1'b0;
        end else if (!w_held && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Write commit and response
    // ------------------------------------------------------------------------
    // The table is read-only: writes into it are refused, not silently dropped,
    // so software notices a stray store. Variant code 3 is refused as well.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            variant <= `VARIANT_RESET;
        end else if (wr_commit) begin
            s_axi_bvalid <= 1'b1;
            if (!aligned(aw_addr)) begin
                s_axi_bresp <= `RESP_SLVERR;
            end else if (wr_index == `VARIANT_IDX) begin
                if (w_strb[0] && (w_data[1:0] == 2'h3)) begin
                    s_axi_bresp <= `RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `RESP_OKAY;
                    if (w_strb[0]) begin
                        variant <= w_data[1:0];
                    end
                end
            end else if ((wr_index >= `TABLE_FIRST_IDX) && (wr_index <= `TABLE_LAST_IDX)) begin
                s_axi_bresp <= `RESP_SLVERR;
            end else begin
                s_axi_bresp <= `RESP_DECERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
    end

    // ------------------------------------------------------------------------
    // Read address channel
    // ------------------------------------------------------------------------
    // One read at a time: ready stays low while data waits to be taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
        end else if (!s_axi_rvalid || s_axi_rready) begin
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Read data channel
    // ------------------------------------------------------------------------
    // Each table byte sits in bits 7:0 of its own word; upper bits read zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            if (!rd_aligned) begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RESP_SLVERR;
            end else if (table_hit) begin
                s_axi_rdata <= {24'h000000, table_byte};
                s_axi_rresp <= `RESP_OKAY;
            end else if (rd_index == `VARIANT_IDX) begin
                s_axi_rdata <= {30'h0, variant};
                s_axi_rresp <= `RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RESP_DECERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end
    end

endmodule // param_timing_axil

/* File: rtl/param_timing_defines.vh */
// Constants for the parameter-page timing-capability table and its bus slave
`ifndef PARAM_TIMING_DEFINES_VH
`define PARAM_TIMING_DEFINES_VH

// ----------------------------------------------------------------------------
// Byte positions in the parameter page (register index; byte address = 4 x index)
// ----------------------------------------------------------------------------
`define ASYNC_MODES_LO_IDX 10'h090
`define ASYNC_MODES_HI_IDX 10'h091
`define RSVD_A_LO_IDX 10'h092
`define RSVD_A_HI_IDX 10'h093
`define DDR_MODES_LO_IDX 10'h094
`define DDR_MODES_HI_IDX 10'h095
`define ASYNC_FEATURES_IDX 10'h096
`define RSVD_B_IDX 10'h097
`define DDR_FEATURES_IDX 10'h098
`define PROG_TIME_LO_IDX 10'h099
`define PROG_TIME_HI_IDX 10'h09A
`define ERASE_TIME_LO_IDX 10'h09B
`define ERASE_TIME_HI_IDX 10'h09C
`define READ_TIME_LO_IDX 10'h09D
`define READ_TIME_HI_IDX 10'h09E
`define MP_READ_TIME_LO_IDX 10'h09F
`define MP_READ_TIME_HI_IDX 10'h0A0
`define COL_SETUP_LO_IDX 10'h0A1
`define COL_SETUP_HI_IDX 10'h0A2
`define TABLE_FIRST_IDX 10'h090
`define TABLE_LAST_IDX 10'h0A2

// ----------------------------------------------------------------------------
// Table contents, low byte first
// ----------------------------------------------------------------------------
`define ASYNC_MODES_VAL 16'h003F
`define DDR_MODES_NONE 16'h0000
`define DDR_MODES_TO4 16'h001F
`define DDR_MODES_TO5 16'h003F
`define DDR_FEATURES_VAL 8'h00
`define MAX_PROGRAM_PAGE_TIME_US 16'h09C4
`define MAX_BLOCK_ERASE_TIME_US 16'h2EE0
`define MAX_PAGE_READ_TIME_US 16'h004B
`define MAX_MP_PAGE_READ_TIME_US 16'h004B
`define COLUMN_CHANGE_SETUP_TIME_NS 16'h00C8
`define RESERVED_BYTE 8'h00

// ----------------------------------------------------------------------------
// Variant select register
// ----------------------------------------------------------------------------
`define VARIANT_IDX 10'h0C0
`define VARIANT_NONE 2'h0
`define VARIANT_TO4 2'h1
`define VARIANT_TO5 2'h2
`define VARIANT_RESET 2'h2

// ----------------------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

/* File: rtl/timing_table_rom.v */
// Constant lookup of the timing-capability bytes of the parameter page
`timescale 1ns/1ps
`include "param_timing_defines.vh"

module timing_table_rom (
    input wire [9:0] byte_index, // Parameter-page byte position
    input wire [1:0] variant, // Synchronous speed-grade variant
    output reg [7:0] byte_data, // Byte value, zero outside the table
    output reg hit // Index lies inside the table
);

    // ------------------------------------------------------------------------
    // Variant-dependent synchronous mode mask
    // ------------------------------------------------------------------------
    reg [15:0] ddr_mask;

    // Two-byte values held as parameters so each byte can be part-selected
    localparam [15:0] ASYNC_MODES = `ASYNC_MODES_VAL;
    localparam [15:0] PROG_TIME = `MAX_PROGRAM_PAGE_TIME_US;
    localparam [15:0] ERASE_TIME = `MAX_BLOCK_ERASE_TIME_US;
    localparam [15:0] READ_TIME = `MAX_PAGE_READ_TIME_US;
    localparam [15:0] MP_READ_TIME = `MAX_MP_PAGE_READ_TIME_US;
    localparam [15:0] COL_SETUP = `COLUMN_CHANGE_SETUP_TIME_NS;

    // Unknown variant codes report no synchronous support
    always @* begin
        case (variant)
            `VARIANT_NONE: ddr_mask = `DDR_MODES_NONE;
            `VARIANT_TO4: ddr_mask = `DDR_MODES_TO4;
            `VARIANT_TO5: ddr_mask = `DDR_MODES_TO5;
            default: ddr_mask = `DDR_MODES_NONE;
        endcase
    end

    // ------------------------------------------------------------------------
    // Byte selection; lower address always carries the low-order byte
    // ------------------------------------------------------------------------
    always @* begin
        hit = (byte_index >= `TABLE_FIRST_IDX) && (byte_index <= `TABLE_LAST_IDX);
        case (byte_index)
            `ASYNC_MODES_LO_IDX: byte_data = ASYNC_MODES[7:0];
            `ASYNC_MODES_HI_IDX: byte_data = ASYNC_MODES[15:8];
            `RSVD_A_LO_IDX: byte_data = `RESERVED_BYTE;
            `RSVD_A_HI_IDX: byte_data = `RESERVED_BYTE;
            `DDR_MODES_LO_IDX: byte_data = ddr_mask[7:0];
            `DDR_MODES_HI_IDX: byte_data = ddr_mask[15:8];
            `ASYNC_FEATURES_IDX: byte_data = `RESERVED_BYTE;
            `RSVD_B_IDX: byte_data = `RESERVED_BYTE;
            `DDR_FEATURES_IDX: byte_data = `DDR_FEATURES_VAL;
            `PROG_TIME_LO_IDX: byte_data = PROG_TIME[7:0];
            `PROG_TIME_HI_IDX: byte_data = PROG_TIME[15:8];
            `ERASE_TIME_LO_IDX: byte_data = ERASE_TIME[7:0];
            `ERASE_TIME_HI_IDX: byte_data = ERASE_TIME[15:8];
            `READ_TIME_LO_IDX: byte_data = READ_TIME[7:0];
            `READ_TIME_HI_IDX: byte_data = READ_TIME[15:8];
            `MP_READ_TIME_LO_IDX: byte_data = MP_READ_TIME[7:0];
            `MP_READ_TIME_HI_IDX: byte_data = MP_READ_TIME[15:8];
            `COL_SETUP_LO_IDX: byte_data = COL_SETUP[7:0];
            `COL_SETUP_HI_IDX: byte_data = COL_SETUP[15:8];
            default: byte_data = 8'h00;
        endcase
    end

endmodule // timing_table_rom

/* File: tb/param_timing_chk.sv */
// Assertions on the ports of the timing-table bus slave
`timescale 1ns/1ps
module param_timing_chk #(
    parameter ADDR_W = 12 // Byte address width
) (
    input wire aclk, // Clock
    input wire aresetn, // Sync reset, active low
    input wire s_axi_awvalid, // Write address valid
    input wire s_axi_awready, // Write address ready
    input wire s_axi_wvalid, // Write data valid
    input wire s_axi_wready, // Write data ready
    input wire s_axi_bvalid, // Write response valid
    input wire [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    input wire s_axi_arready, // Read address ready
    input wire [31:0] s_axi_rdata, // Read data
    input wire s_axi_rvalid, // Read data valid
    input wire s_axi_rready // Read data ready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Read address taken this edge
    wire ar_take = s_axi_arvalid && s_axi_arready;

    // ------------------------------------------------------------------
    // Handshake timing
    // ------------------------------------------------------------------
    chk_read_answer: assert property (ar_take |=> s_axi_rvalid)
        else $error("read not answered one cycle after address");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped while stalled");
    chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted while one is pending");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");

    // ------------------------------------------------------------------
    // Table contents, tied to the address that was taken
    // ------------------------------------------------------------------
    chk_async_mask: assert property (ar_take && s_axi_araddr == 12'h240 |=>
        s_axi_rdata == 32'h0000003F) else $error("async mode mask wrong");
    chk_ddr_mask: assert property (ar_take && s_axi_araddr == 12'h250 |=>
        s_axi_rdata inside {32'h0, 32'h1F, 32'h3F}) else $error("ddr mode mask wrong");
    chk_prog_low: assert property (ar_take && s_axi_araddr == 12'h264 |=>
        s_axi_rdata == 32'h000000C4) else $error("program time low byte wrong");
    chk_col_setup: assert property (ar_take && s_axi_araddr == 12'h284 |=>
        s_axi_rdata == 32'h000000C8) else $error("column setup low byte wrong");
    chk_rsvd_zero: assert property (ar_take && s_axi_araddr inside
        {12'h248, 12'h24C, 12'h258, 12'h25C} |=> s_axi_rdata == 32'h0)
        else $error("reserved byte not zero");
endmodule // param_timing_chk

bind param_timing_axil param_timing_chk #(.ADDR_W(ADDR_W)) chk_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);

/* File: tb/axil_host.sv */
// Host controller model: bus master reading the parameter-page table
`timescale 1ns/1ps
module axil_host #(
    parameter ADDR_W = 12 // Byte address width
) (
    input wire aclk, // Clock
    output logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    output logic [2:0] s_axi_awprot, // Write protection
    output logic s_axi_awvalid, // Write address valid
    input wire s_axi_awready, // Write address ready
    output logic [31:0] s_axi_wdata, // Write data
    output logic [3:0] s_axi_wstrb, // Write strobes
    output logic s_axi_wvalid, // Write data valid
    input wire s_axi_wready, // Write data ready
    input wire [1:0] s_axi_bresp, // Write response
    input wire s_axi_bvalid, // Write response valid
    output logic s_axi_bready, // Write response ready
    output logic [ADDR_W-1:0] s_axi_araddr, // Read address
    output logic [2:0] s_axi_arprot, // Read protection
    output logic s_axi_arvalid, // Read address valid
    input wire s_axi_arready, // Read address ready
    input wire [31:0] s_axi_rdata, // Read data
    input wire [1:0] s_axi_rresp, // Read response
    input wire s_axi_rvalid, // Read data valid
    output logic s_axi_rready // Read data ready
);
    // Quiet bus at time zero
    initial begin
        s_axi_awaddr = '0;
        s_axi_awprot = 3'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arprot = 3'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end

    // Address and data offered together, each released at its own handshake
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // Released payload flips so a stale value cannot pass for a live one
        s_axi_awaddr <= ~a;
        s_axi_wdata <= ~d;
    endtask

    // Read with a chosen stall before accepting the data
    task automatic rd(input logic [ADDR_W-1:0] a, input int stall, output logic [31:0] d,
                      output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        repeat (stall) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule // axil_host

/* File: tb/tb_top.sv */
// Self-checking bench for the parameter-page timing table slave
`timescale 1ns/1ps
`include "param_timing_defines.vh"
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, hi;
    logic [3:0] s_axi_wstrb;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int idx;
    int fld[6] = '{144, 153, 155, 157, 159, 161};
    logic [15:0] fval[6] = '{16'h003F, 16'h09C4, 16'h2EE0, 16'h004B, 16'h004B, 16'h00C8};

    always #4 aclk = ~aclk;

    param_timing_axil #(.ADDR_W(12)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    axil_host #(.ADDR_W(12)) host (
        .aclk(aclk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    // Expected table byte for a given speed-grade variant
    function automatic logic [31:0] exp_byte(input int i, input int sel);
        case (i)
            144: return 32'h3F;
            148: return sel == 0 ? 32'h00 : (sel == 1 ? 32'h1F : 32'h3F);
            153: return 32'hC4;
            154: return 32'h09;
            155: return 32'hE0;
            156: return 32'h2E;
            157, 159: return 32'h4B;
            161: return 32'hC8;
            default: return 32'h00;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Read with a random stall, then compare data and response
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        host.rd(a, $urandom % 4, d, r);
        check(d, exp);
        check({30'h0, r}, {30'h0, er});
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Hang guard: the sequence needs a few thousand cycles at most
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(47121));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // Whole table in order, back to back, at the reset variant
        for (idx = 144; idx <= 162; idx++) rd_chk(12'(4 * idx), exp_byte(idx, 2), 2'h0);
        // Random bytes of the table
        repeat (150) begin
            idx = $urandom_range(162, 144);
            rd_chk(12'(4 * idx), exp_byte(idx, 2), 2'h0);
        end
        // Variant codes 0 to 2 each select their own ddr mask
        for (idx = 0; idx < 3; idx++) begin
            host.wr(12'h300, idx, 4'hF, r);
            check({30'h0, r}, {30'h0, `RESP_OKAY});
            rd_chk(12'h300, idx, 2'h0);
            rd_chk(12'h250, exp_byte(148, idx), 2'h0);
            rd_chk(12'h254, 32'h0, 2'h0);
        end
        // Refused code and strobe-less write leave mode 0 to 5 in place
        host.wr(12'h300, 32'h3, 4'hF, r);
        check({30'h0, r}, {30'h0, `RESP_SLVERR});
        host.wr(12'h300, 32'h0, 4'h0, r);
        check({30'h0, r}, {30'h0, `RESP_OKAY});
        rd_chk(12'h250, 32'h3F, 2'h0);
        // Table is read-only; a write into it is refused and the byte keeps its value
        host.wr(12'h264, 32'hFF, 4'hF, r);
        check({30'h0, r}, {30'h0, `RESP_SLVERR});
        rd_chk(12'h264, 32'hC4, 2'h0);
        // Unmapped and misaligned writes are refused and leave the variant alone
        host.wr(12'h400, 32'h1, 4'hF, r);
        check({30'h0, r}, {30'h0, `RESP_DECERR});
        host.wr(12'h302, 32'h1, 4'hF, r);
        check({30'h0, r}, {30'h0, `RESP_SLVERR});
        rd_chk(12'h300, 32'h2, 2'h0);
        rd_chk(12'h241, 32'h0, `RESP_SLVERR);
        rd_chk(12'h23C, 32'h0, `RESP_DECERR);
        rd_chk(12'h400, 32'h0, `RESP_DECERR);
        // Two-byte fields assembled low byte first
        foreach (fld[k]) begin
            host.rd(12'(4 * fld[k]), 0, d, r);
            host.rd(12'(4 * fld[k] + 4), 1, hi, r);
            check({16'h0, hi[7:0], d[7:0]}, {16'h0, fval[k]});
        end
        // Mid-run reset: outputs drop and the mode 0 to 5 variant returns
        host.wr(12'h300, 32'h0, 4'hF, r);
        check({30'h0, r}, {30'h0, `RESP_OKAY});
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        check({23'h0, s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid,
               s_axi_bresp, s_axi_rresp}, 32'h0);
        check(s_axi_rdata, 32'h0);
        aresetn <= 1'b1;
        rd_chk(12'h300, 32'h2, 2'h0);
        rd_chk(12'h250, exp_byte(148, 2), 2'h0);
        wrap_up();
    end
endmodule // tb_top
